/* core/tsr_status_readback.v */
// i2c read-mode status slave of the tuner: two status bytes
// assumes scl/sda arrive from pins; flags are analog-side levels
`timescale 1ns/1ps
`include "tsr_regs.vh"
module tsr_status_readback (
    // clock and reset
    input  wire       ref_clk,
    input  wire       resetn,
    // i2c pins
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_out,
    output wire       sda_oe_n,
    input  wire [1:0] addr_select,
    // analog-side status
    input  wire       supply_low,
    input  wire       pll_locked,
    input  wire       tune_high_flag,
    input  wire       tune_low_flag,
    input  wire       cal_fault_flag,
    input  wire [1:0] rf_level_code,
    // divider word sources
    input  wire       auto_mode,
    input  wire [4:0] host_divider_word,
    input  wire [4:0] cal_divider_word,
    // host settings passed to analog side
    input  wire [1:0] high_threshold_select,
    input  wire       input_attenuation_select,
    output reg  [1:0] high_tune_threshold_sel,
    output reg        attenuate_20db,
    // status
    output reg        power_up_flag,
    output reg        frame_active
);
    localparam S_IDLE = 5'h01;
    localparam S_ADDR = 5'h02;
    localparam S_AACK = 5'h04;
    localparam S_DATA = 5'h08;
    localparam S_MACK = 5'h10;

    wire [4:0] sync_q;
    tsr_sync2 #(.W(5)) u_sync (
        .clk    (ref_clk),
        .resetn (resetn),
        .d      ({scl_in, sda_in, supply_low, addr_select}),
        .q      (sync_q)
    );
    wire scl_s = sync_q[4];
    wire sda_s = sync_q[3];
    wire uv_s  = sync_q[2];
    wire [1:0] as_s = sync_q[1:0];

    reg        scl_d_r;
    reg        sda_d_r;
    reg  [4:0] state_r;
    reg  [2:0] bit_cnt_r;
    reg  [7:0] shift_r;
    reg        byte_idx_r;
    reg        drive_low_r;
    reg        read_done_r;
    // set on the 8th address rise; the start's own scl fall must not compare
    reg        addr_full_r;

    wire scl_rise = scl_s & ~scl_d_r;
    wire scl_fall = ~scl_s & scl_d_r;
    wire start_c  = scl_s & sda_d_r & ~sda_s;
    wire stop_c   = scl_s & ~sda_d_r & sda_s;

    wire [4:0] dw_use = auto_mode ? cal_divider_word : host_divider_word;

    function [7:0] status_byte;
        input sel;
        begin
            if (sel == `TSR_OFS_STATUS_FLAGS)
                status_byte = {power_up_flag, pll_locked, tune_high_flag,
                               tune_low_flag, cal_fault_flag, `TSR_UNDEF_BITS};
            else
                status_byte = {`TSR_BYTE1_MARK, rf_level_code, dw_use};
        end
    endfunction

    always @(posedge ref_clk) begin
        if (!resetn) begin
            high_tune_threshold_sel <= 2'h0;
            attenuate_20db          <= 1'h0;
        end else begin
            high_tune_threshold_sel <= high_threshold_select;
            attenuate_20db          <= input_attenuation_select;
        end
    end

    always @(posedge ref_clk) begin
        if (!resetn) begin
            scl_d_r     <= 1'h1;
            sda_d_r     <= 1'h1;
            state_r     <= S_IDLE;
            bit_cnt_r   <= 3'h0;
            shift_r     <= 8'h00;
            byte_idx_r  <= 1'h0;
            drive_low_r <= 1'h0;
            read_done_r <= 1'h0;
            addr_full_r <= 1'h0;
            frame_active <= 1'h0;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
            read_done_r <= 1'h0;
            if (start_c) begin
                state_r     <= S_ADDR;
                bit_cnt_r   <= 3'h0;
                addr_full_r <= 1'h0;
                drive_low_r <= 1'h0;
                frame_active <= 1'h1;
            end else if (stop_c) begin
                state_r     <= S_IDLE;
                drive_low_r <= 1'h0;
                frame_active <= 1'h0;
            end else begin
                case (state_r)
                    S_IDLE: begin
                        drive_low_r <= 1'h0;
                    end
                    S_ADDR: begin
                        if (scl_rise) begin
                            shift_r   <= {shift_r[6:0], sda_s};
                            bit_cnt_r <= bit_cnt_r + 3'h1;
                            if (bit_cnt_r == 3'h7)
                                addr_full_r <= 1'h1;
                        end
                        if (scl_fall && addr_full_r) begin
                            addr_full_r <= 1'h0;
                            // match address, read direction only
                            if (shift_r == {`TSR_ADDR_BASE, as_s, 1'b1}) begin
                                drive_low_r <= 1'h1;
                                state_r     <= S_AACK;
                            end else begin
                                state_r <= S_IDLE;
                            end
                        end
                    end
                    S_AACK: begin
                        if (scl_fall) begin
                            byte_idx_r  <= `TSR_OFS_STATUS_FLAGS;
                            shift_r     <= status_byte(`TSR_OFS_STATUS_FLAGS);
                            drive_low_r <= ~status_byte(`TSR_OFS_STATUS_FLAGS)
                                           [`TSR_BIT_POWER_UP];
                            bit_cnt_r   <= 3'h0;
                            state_r     <= S_DATA;
                        end
                    end
                    S_DATA: begin
                        if (scl_fall) begin
                            bit_cnt_r <= bit_cnt_r + 3'h1;
                            if (bit_cnt_r == 3'h7) begin
                                drive_low_r <= 1'h0;
                                state_r     <= S_MACK;
                            end else begin
                                shift_r     <= {shift_r[6:0], 1'b0};
                                drive_low_r <= ~shift_r[6];
                            end
                        end
                    end
                    S_MACK: begin
                        if (scl_rise) begin
                            if (byte_idx_r == `TSR_OFS_LEVEL_DIVIDER)
                                read_done_r <= 1'h1;
                        end
                        if (scl_fall) begin
                            if (sda_d_r == 1'b0 &&
                                byte_idx_r == `TSR_OFS_STATUS_FLAGS) begin
                                byte_idx_r  <= `TSR_OFS_LEVEL_DIVIDER;
                                shift_r     <= status_byte(`TSR_OFS_LEVEL_DIVIDER);
                                drive_low_r <= 1'h0;
                                bit_cnt_r   <= 3'h0;
                                state_r     <= S_DATA;
                            end else begin
                                state_r <= S_IDLE;
                            end
                        end
                    end
                    default: state_r <= S_IDLE;
                endcase
            end
        end
    end

    // power-up flag; set wins over clear
    always @(posedge ref_clk) begin
        if (!resetn)
            power_up_flag <= `TSR_POWER_UP_RESET;
        else if (uv_s)
            power_up_flag <= 1'h1;
        else if (read_done_r)
            power_up_flag <= 1'h0;
    end

    // byte1 first bit is constant 1, so released line at load is correct
    assign sda_out  = 1'b0;
    assign sda_oe_n = ~drive_low_r;
endmodule // tsr_status_readback

/* core/tsr_sync2.v */
// two-flop synchroniser for a group of pin inputs
// assumes inputs asynchronous to clk
`timescale 1ns/1ps
module tsr_sync2 #(
    parameter W = 1
) (
    // clock and reset
    input  wire         clk,
    input  wire         resetn,
    // data
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] meta_r;
    always @(posedge clk) begin
        if (!resetn) begin
            meta_r <= {W{1'b1}};
            q      <= {W{1'b1}};
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // tsr_sync2

/* include/tsr_regs.vh */
// constants for the tuner status readback block
// assumes an i2c slave on an open-drain bus, sampled by ref_clk
//
// What this block does
// - read frame is start, address+ack, byte0, ack, byte1, ack, stop.
// - each status byte leaves msb first.
// - power-up flag bit7 of byte0 set on supply ramp-up.
// - power-up flag clears after the first completed read.
// - power-up flag sets again on supply undervoltage.
// - byte0 bit6 shows synthesizer lock.
// - byte0 bit5 shows tuning voltage above high threshold.
// - byte0 bit4 shows tuning voltage below low threshold.
// - byte0 bit3 shows calibration divider word out of range.
// - byte1 is constant 1, level code, five-bit divider word.
// - level code 0..3 by input power bands from analog detector.
// - divider field returns divider word in use internally.
// - manual mode shows host word, automatic shows calibrated word.
// - high threshold chosen by two-bit host setting.
// - attenuation bit selects 20 dB attenuation when set.
`ifndef TSR_REGS_VH
`define TSR_REGS_VH
`define TSR_OFS_STATUS_FLAGS   1'h0
`define TSR_OFS_LEVEL_DIVIDER  1'h1
`define TSR_BIT_POWER_UP       7
`define TSR_BIT_LOCK           6
`define TSR_BIT_TUNE_HIGH      5
`define TSR_BIT_TUNE_LOW       4
`define TSR_BIT_CAL_FAULT      3
`define TSR_BYTE1_MARK         1'h1
`define TSR_UNDEF_BITS         3'h0
`define TSR_ADDR_BASE          5'h10
`define TSR_POWER_UP_RESET     1'h1
`endif

/* verif/test_tsr_status_readback.sv */
// testbench: read frames through the master model, results checked from a queue
// assumes design, checker and master model compiled before it
`timescale 1ns/1ps
`include "tsr_regs.vh"
module test_tsr_status_readback;
    logic       ref_clk, resetn, supply_low, pll_locked, tune_high_flag, tune_low_flag;
    logic       cal_fault_flag, auto_mode, input_attenuation_select, pwr;
    logic [1:0] addr_select, rf_level_code, high_threshold_select;
    logic [4:0] host_divider_word, cal_divider_word;
    logic [8:0] exp_q[$], e;
    wire        scl, sda_drv, rx_stb, sda_out, sda_oe_n, power_up_flag;
    wire  [8:0] rx;
    wire        sda = sda_drv & (sda_oe_n | sda_out);
    int         failures = 0, samples_checked = 0, cyc = 0;
    tsr_status_readback tsr_status_readback_inst (.ref_clk, .resetn, .scl_in(scl), .sda_in(sda),
        .sda_out, .sda_oe_n, .addr_select, .supply_low, .pll_locked, .tune_high_flag,
        .tune_low_flag, .cal_fault_flag, .rf_level_code, .auto_mode, .host_divider_word,
        .cal_divider_word, .high_threshold_select, .input_attenuation_select,
        .high_tune_threshold_sel(), .attenuate_20db(), .power_up_flag, .frame_active());
    tsr_i2c_master tsr_i2c_master_inst (.scl, .sda_drv, .rx_stb, .rx, .sda);
    initial begin
        ref_clk = 0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (++cyc == 30000) begin
        failures++;
        test_done;
    end
    always @(posedge rx_stb) begin
        e = exp_q.pop_front();
        samples_checked++;
        if (rx !== e) begin
            failures++;
            $display("Error rx byte and ack expected %h seen %h", e, rx);
        end
    end
    task chkp;
        samples_checked++;
        if (power_up_flag !== pwr) begin
            failures++;
            $display("Error power_up_flag expected %b seen %b", pwr, power_up_flag);
        end
    endtask
    task setin;
        @(posedge ref_clk) #1;
        {pll_locked, tune_high_flag, tune_low_flag, cal_fault_flag, rf_level_code, auto_mode,
         host_divider_word, cal_divider_word, high_threshold_select, input_attenuation_select,
         addr_select} = 22'($urandom);
    endtask
    // nb data bytes read; a1 is the master's bit after the second byte
    task frame(input [7:0] ad, input int nb, input logic a1);
        exp_q.push_back({ad, ad != {`TSR_ADDR_BASE, addr_select, 1'h1}});
        exp_q.push_back({pwr, pll_locked, tune_high_flag, tune_low_flag, cal_fault_flag, 3'h0,
                         nb == 1});
        exp_q.push_back({1'h1, rf_level_code, auto_mode ? cal_divider_word : host_divider_word,
                         a1});
        tsr_i2c_master_inst.start;
        tsr_i2c_master_inst.xfer({ad, 1'h1});
        if (nb > 0) tsr_i2c_master_inst.xfer({8'hff, nb == 1});
        if (nb > 1) tsr_i2c_master_inst.xfer({8'hff, a1});
        if (nb > 1) pwr = 0;
        exp_q.delete();
        tsr_i2c_master_inst.stop;
    endtask
    task test_done;
        if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        {resetn, supply_low, pll_locked, tune_high_flag, tune_low_flag, cal_fault_flag} = '0;
        {auto_mode, input_attenuation_select, addr_select, rf_level_code} = '0;
        {high_threshold_select, host_divider_word, cal_divider_word} = '0;
        pwr = 1;
        void'($urandom(48285));
        repeat (10) @(posedge ref_clk);
        #1 resetn = 1;
        setin;
        frame({`TSR_ADDR_BASE, addr_select + 2'h1, 1'h1}, 0, 1);
        frame({`TSR_ADDR_BASE, addr_select, 1'h0}, 0, 1);
        frame({`TSR_ADDR_BASE, addr_select, 1'h1}, 1, 1);
        chkp;
        for (int i = 0; i < 8; i++) begin
            setin;
            tsr_i2c_master_inst.slow = $urandom % 30;
            if (i == 4) begin
                supply_low = 1;
                repeat (10) @(posedge ref_clk);
                #1 supply_low = 0;
                pwr = 1;
                chkp;
            end
            frame({`TSR_ADDR_BASE, addr_select, 1'h1}, 2, i[0]);
            chkp;
        end
        @(posedge ref_clk) #1 resetn = 0;
        repeat (10) @(posedge ref_clk);
        #1 resetn = 1;
        pwr = 1;
        chkp;
        repeat (3) @(posedge ref_clk);
        frame({`TSR_ADDR_BASE, addr_select, 1'h1}, 2, 1);
        chkp;
        test_done;
    end
endmodule // test_tsr_status_readback

/* verif/tsr_i2c_master.sv */
// partner: behavioural bus master, 80 ns bus clock, stretchable low phase
// assumes sda is the resolved open-drain line with a pull-up
`timescale 1ns/1ps
module tsr_i2c_master (
    output logic       scl, sda_drv, rx_stb,
    output logic [8:0] rx,
    input  wire        sda
);
    int slow = 0;
    initial begin
        scl = 1;
        sda_drv = 1;
        rx_stb = 0;
    end
    task start;
        #10 sda_drv = 1;
        #30 scl = 1;
        #40 sda_drv = 0;
        #40 scl = 0;
    endtask
    task stop;
        #10 sda_drv = 0;
        #30 scl = 1;
        #40 sda_drv = 1;
        #40;
    endtask
    // sampled late in the high phase since slave data moves after scl falls
    task xfer(input [8:0] w);
        for (int i = 8; i >= 0; i--) begin
            #(10 + slow) sda_drv = w[i];
            #30 scl = 1;
            #38 rx[i] = sda;
            #2 scl = 0;
        end
        rx_stb = 1;
        #1 rx_stb = 0;
    endtask
endmodule // tsr_i2c_master

/* verif/tsr_props.sv */
// checker: port-level properties of the status readback slave
// assumes bound to the design top, one ref_clk domain
`timescale 1ns/1ps
module tsr_props (
    input wire       ref_clk, resetn, scl_in, sda_out, sda_oe_n, supply_low, frame_active,
    input wire       input_attenuation_select, attenuate_20db, power_up_flag,
    input wire [1:0] high_threshold_select, high_tune_threshold_sel
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    AST_THR_LAG: assert property ($past(resetn) |->
        high_tune_threshold_sel == $past(high_threshold_select)) else $error("threshold lag");
    AST_ATT_LAG: assert property ($past(resetn) |->
        attenuate_20db == $past(input_attenuation_select)) else $error("attenuation lag");
    AST_OPEN_DRAIN: assert property (
        sda_out == 1'h0) else $error("sda driven high");
    AST_PULL_IN_FRAME: assert property (
        !sda_oe_n |-> frame_active) else $error("pull outside frame");
    AST_START_SCL_HIGH: assert property (
        $rose(frame_active) |-> $past(scl_in)) else $error("start with scl low");
    AST_RELEASE_AT_END: assert property (
        $fell(frame_active) |-> sda_oe_n && $past(sda_oe_n)) else $error("held at stop");
    AST_PWR_SET: assert property (
        supply_low [*4] |=> power_up_flag) else $error("flag not set");
    AST_PWR_CAUSE: assert property ($rose(power_up_flag) |->
        $past(supply_low, 2) || $past(supply_low, 3) || $past(supply_low, 4))
        else $error("flag set without cause");
    AST_PWR_CLR: assert property (
        $fell(power_up_flag) |-> frame_active) else $error("flag cleared outside frame");
endmodule // tsr_props
bind tsr_status_readback tsr_props tsr_props_inst (.*);
